// ===== dv/daf_aux_chk.sv
// Concurrent checks on the ports of the auxiliary function block
`timescale 1ns/1ps
module daf_aux_chk (
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // Commands and settings
   input wire runCmd,
   input wire jogCmd,
   input wire reverse_inhibit,
   input wire [15:0] freq_detect_level_one,
   input wire [9:0] freq_detect_hysteresis_one,
   input wire [15:0] poweron_hours_threshold,
   input wire [15:0] running_hours_threshold,
   // Outputs watched
   input wire [15:0] outFreq_q,
   input wire outReverse_q,
   input wire running_q,
   input wire [1:0] startMethodActive_q,
   input wire startBlocked_q,
   input wire deadTime_q,
   input wire freq_detector_one_q,
   input wire poweronArrive_q,
   input wire runtimeArrive_q,
   input wire [15:0] poweron_hours_counter,
   input wire [15:0] running_hours_counter
);
   // Release level of the detector
   wire [25:0] hystProd = freq_detect_level_one * freq_detect_hysteresis_one;
   wire [25:0] hystAmt = hystProd / 26'h00003e8;
   wire [15:0] clrLvl = freq_detect_level_one - hystAmt[15:0];
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_detect_set:
      assert property (outFreq_q > freq_detect_level_one |-> ##[1:2] freq_detector_one_q)
      else $error("detector missed set");
   a_detect_clear:
      assert property (outFreq_q < clrLvl |-> ##[1:2] !freq_detector_one_q)
      else $error("detector missed release");
   a_poweron_arrive:
      assert property (poweron_hours_counter >= poweron_hours_threshold |-> ##[0:2] poweronArrive_q)
      else $error("power-on arrival missing");
   a_poweron_early:
      assert property ((poweron_hours_counter < poweron_hours_threshold) [*2] |-> !poweronArrive_q)
      else $error("power-on arrival early");
   a_runtime_arrive:
      assert property (running_hours_counter >= running_hours_threshold |-> ##[0:2] runtimeArrive_q)
      else $error("run-time arrival missing");
   a_dead_zero:
      assert property (deadTime_q && $past(deadTime_q) |-> outFreq_q == 16'h0000)
      else $error("output moving in dead time");
   a_reverse_lock:
      assert property ($rose(outReverse_q) |-> !$past(reverse_inhibit))
      else $error("reversed while inhibited");
   a_blocked_idle:
      assert property ((startBlocked_q && !running_q) ##1 startBlocked_q |-> !running_q)
      else $error("running while blocked");
   a_jog_direct:
      assert property ((jogCmd && !runCmd) [*4] ##0 running_q |-> startMethodActive_q == 2'h0)
      else $error("jog start method wrong");
   c_dead: cover property ($rose(deadTime_q));
   c_unblock: cover property ($fell(startBlocked_q));
   c_release: cover property ($fell(freq_detector_one_q));
endmodule // daf_aux_chk

bind daf_aux daf_aux_chk u_chk (.mclk, .sys_rst, .runCmd, .jogCmd, .reverse_inhibit,
   .freq_detect_level_one, .freq_detect_hysteresis_one, .poweron_hours_threshold,
   .running_hours_threshold, .outFreq_q, .outReverse_q, .running_q, .startMethodActive_q,
   .startBlocked_q, .deadTime_q, .freq_detector_one_q, .poweronArrive_q, .runtimeArrive_q,
   .poweron_hours_counter, .running_hours_counter);

// ===== dv/daf_aux_tb.sv
// Self-checking bench for the auxiliary function block
`timescale 1ns/1ps
module daf_aux_tb;
   logic mclk, sys_rst, runCmd, jogCmd, reverseCmd, faultReset, reverse_inhibit;
   logic start_protection_select;
   logic [1:0] accelSelect, below_floor_action, start_method_select, stop_method_select;
   logic [15:0] freqSetpoint, maxFreq, lowerLimitFreq, loadLevel, jog_target_freq;
   logic [15:0] jog_accel_time, jog_decel_time, accel_time_set_one, decel_time_set_one;
   logic [15:0] accel_time_set_two, decel_time_set_two, accel_time_set_three;
   logic [15:0] decel_time_set_three, accel_time_set_four, decel_time_set_four;
   logic [15:0] skip_point_one, skip_point_two, skip_band_amplitude;
   logic [15:0] poweron_hours_threshold, running_hours_threshold, freq_detect_level_one;
   logic [15:0] outFreq_q, poweron_hours_counter, running_hours_counter;
   logic [21:0] direction_change_dead_time;
   logic [13:0] droop_amount;
   logic [9:0] freq_detect_hysteresis_one;
   logic outReverse_q, running_q, startBlocked_q, deadTime_q, freq_detector_one_q;
   logic poweronArrive_q, runtimeArrive_q;
   logic [1:0] startMethodActive_q;
   int failures, checks_done;

   // Ten cycles per second keeps one hour near 36000 cycles
   daf_aux #(.CYC_PER_SEC(10)) DUT (.*);
   daf_motor MOT (.mclk, .sys_rst, .running(running_q), .loadLevel);

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic cyc(int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   // A ramp with a nonzero time moves one step per 400 cycles at most
   task automatic waitf(logic [15:0] e);
      for (int i = 0; i < 12000 && outFreq_q !== e; i++) cyc(1);
      cmp("outFreq", e, outFreq_q);
   endtask

   task automatic go(logic [15:0] sp, logic [15:0] e);
      freqSetpoint = sp;
      waitf(e);
   endtask

   task automatic restart();
      runCmd = 1'b0;
      cyc(10);
      runCmd = 1'b1;
   endtask

   task automatic wrap_up();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      #(25 * 90000);
      failures++;
      wrap_up();
   end

   initial begin
      sys_rst = 1'b1;
      runCmd = 1'b1;
      {jogCmd, reverseCmd, faultReset, reverse_inhibit} = '0;
      {accelSelect, below_floor_action, stop_method_select} = '0;
      start_method_select = 2'h1;
      start_protection_select = 1'b1;
      freqSetpoint = 16'h0008;
      maxFreq = 16'h1388;
      lowerLimitFreq = '0;
      jog_target_freq = 16'h0006;
      {jog_accel_time, jog_decel_time, accel_time_set_one, decel_time_set_one} = '0;
      {accel_time_set_two, decel_time_set_two, decel_time_set_three} = '0;
      {accel_time_set_four, decel_time_set_four, skip_point_one, skip_point_two} = '0;
      accel_time_set_three = 16'h0001;
      jog_decel_time = 16'h0001;
      skip_band_amplitude = 16'h0003;
      direction_change_dead_time = 22'h000001;
      droop_amount = '0;
      poweron_hours_threshold = 16'h0001;
      running_hours_threshold = '0;
      freq_detect_level_one = 16'h0004;
      freq_detect_hysteresis_one = 10'h1f4;
      cyc(12);
      sys_rst = 1'b0;
      cyc(40);
      cmp("blocked", 1, startBlocked_q);
      cmp("running", 0, running_q);
      cmp("runArrive", 1, runtimeArrive_q);
      cmp("pwrArrive", 0, poweronArrive_q);
      cmp("runHours", 0, running_hours_counter);
      restart();
      waitf(16'h0008);
      cyc(2);
      cmp("startMode", 1, startMethodActive_q);
      cmp("detect", 1, freq_detector_one_q);
      go(16'h0003, 16'h0003);
      cyc(4);
      cmp("detect", 1, freq_detector_one_q);
      go(16'h0001, 16'h0001);
      cyc(4);
      cmp("detect", 0, freq_detector_one_q);
      skip_point_one = 16'h000a;
      go(16'h0009, 16'h0007);
      skip_point_one = '0;
      skip_point_two = 16'h000a;
      go(16'h000b, 16'h000d);
      skip_point_two = '0;
      go(16'h000b, 16'h000b);
      // Set three takes two ticks per step, set one jumps to the target in one tick
      accelSelect = 2'h2;
      freqSetpoint = 16'h0011;
      cyc(3200);
      cmp("slowRamp", 1, outFreq_q < 16'h0011);
      waitf(16'h0011);
      accelSelect = 2'h0;
      freqSetpoint = 16'h0017;
      cyc(3200);
      cmp("fastRamp", 16'h0017, outFreq_q);
      lowerLimitFreq = 16'h0006;
      go(16'h0004, 16'h0006);
      below_floor_action = 2'h2;
      waitf(16'h0000);
      cmp("running", 1, running_q);
      below_floor_action = 2'h1;
      cyc(20);
      cmp("running", 0, running_q);
      below_floor_action = 2'h0;
      lowerLimitFreq = '0;
      droop_amount = 14'h001e;
      restart();
      go(16'h0008, 16'h0005);
      reverse_inhibit = 1'b1;
      reverseCmd = 1'b1;
      waitf(16'h0000);
      cyc(100);
      cmp("reverse", 0, outReverse_q);
      reverse_inhibit = 1'b0;
      for (int i = 0; i < 200 && deadTime_q !== 1'b1; i++) cyc(1);
      cmp("dead", 1, deadTime_q);
      cmp("deadFreq", 0, outFreq_q);
      for (int i = 0; i < 45000 && outReverse_q !== 1'b1; i++) cyc(1);
      cmp("reverse", 1, outReverse_q);
      waitf(16'h0005);
      droop_amount = '0;
      runCmd = 1'b0;
      waitf(16'h0000);
      jogCmd = 1'b1;
      waitf(16'h0006);
      cmp("jogMode", 0, startMethodActive_q);
      // Coast is configured, yet jog must still ramp down
      stop_method_select = 2'h1;
      jogCmd = 1'b0;
      cyc(20);
      cmp("jogStop", 1, outFreq_q != 16'h0000);
      waitf(16'h0000);
      runCmd = 1'b1;
      faultReset = 1'b1;
      cyc(5);
      faultReset = 1'b0;
      cyc(20);
      cmp("blocked", 1, startBlocked_q);
      cmp("running", 0, running_q);
      runCmd = 1'b0;
      cyc(10);
      cmp("blocked", 0, startBlocked_q);
      cmp("pwrArrive", 1, poweronArrive_q);
      cmp("pwrHours", 1, poweron_hours_counter >= 16'h0001);
      cmp("runHours", 1, running_hours_counter <= poweron_hours_counter);
      wrap_up();
   end
endmodule // daf_aux_tb

// ===== dv/daf_motor.sv
// Motor load model on the drive output side
`timescale 1ns/1ps
module daf_motor #(
   parameter [15:0] LOAD = 16'h03e8
) (
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // Drive side
   input wire running,
   // Load feedback, 0.1 % of rated
   output reg [15:0] loadLevel
);
   // Shaft load follows the drive one cycle late, never ahead of it
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         loadLevel <= 16'h0000;
      end else begin
         loadLevel <= running ? LOAD : 16'h0000;
      end
   end
endmodule // daf_motor

// ===== include/daf_regs.vh
// Constants for the drive auxiliary function block
`ifndef DAF_REGS_VH
`define DAF_REGS_VH
`define DAF_CLK_HZ 40000000
`define DAF_TICK_NS 10000
`define DAF_TICK_CYC ((`DAF_TICK_NS * (`DAF_CLK_HZ / 1000000)) / 1000)
`define DAF_MS_NS 1000000
`define DAF_MS_CYC ((`DAF_MS_NS * (`DAF_CLK_HZ / 1000000)) / 1000)
`define DAF_TICKS_PER_TENTH 10000
`define DAF_SEC_PER_HOUR 3600
`define DAF_RATED_LOAD 1000
`define DAF_DROOP_DIV 30'h0002710
`define DAF_HYST_DIV 26'h00003e8
`define DAF_JOG_FREQ_RST 16'h00c8
`define DAF_RAMP_TIME_RST 16'hc8
`define DAF_SKIP_RST 16'h0000
`define DAF_DEAD_TIME_RST 22'h000000
`define DAF_FDT_LEVEL_RST 16'h1388
`define DAF_HOURS_RST 16'h0000
`define DAF_HOURS_MAX 16'hffff
`define DAF_ST_RUN 1'h0
`define DAF_ST_DEAD 1'h1
`define DAF_FLOOR_LIMIT 2'h0
`define DAF_FLOOR_STOP 2'h1
`define DAF_FLOOR_ZERO 2'h2
`endif

// ===== verilog/daf_aux.v
// Drive auxiliary functions: jog, ramp sets, skip bands, dead time, droop, detectors
`timescale 1ns/1ps
`include "daf_regs.vh"
module daf_aux #(
   parameter CYC_PER_SEC = `DAF_CLK_HZ
) (
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // Terminal commands (asynchronous pins)
   input wire runCmd,
   input wire jogCmd,
   input wire reverseCmd,
   input wire [1:0] accelSelect,
   input wire faultReset,
   // Frequency setting, 0.01 Hz units
   input wire [15:0] freqSetpoint,
   input wire [15:0] maxFreq,
   input wire [15:0] lowerLimitFreq,
   // Load feedback, 0.1 % of rated
   input wire [15:0] loadLevel,
   // Jog configuration, 0.01 Hz and 0.1 s units
   input wire [15:0] jog_target_freq,
   input wire [15:0] jog_accel_time,
   input wire [15:0] jog_decel_time,
   // Ramp sets, 0.1 s units
   input wire [15:0] accel_time_set_one,
   input wire [15:0] decel_time_set_one,
   input wire [15:0] accel_time_set_two,
   input wire [15:0] decel_time_set_two,
   input wire [15:0] accel_time_set_three,
   input wire [15:0] decel_time_set_three,
   input wire [15:0] accel_time_set_four,
   input wire [15:0] decel_time_set_four,
   // Skip bands, 0.01 Hz units
   input wire [15:0] skip_point_one,
   input wire [15:0] skip_point_two,
   input wire [15:0] skip_band_amplitude,
   // Direction, floor and stop handling
   input wire [21:0] direction_change_dead_time,
   input wire reverse_inhibit,
   input wire [1:0] below_floor_action,
   input wire [1:0] start_method_select,
   input wire [1:0] stop_method_select,
   input wire start_protection_select,
   // Droop, 0.001 Hz units
   input wire [13:0] droop_amount,
   // Hour thresholds
   input wire [15:0] poweron_hours_threshold,
   input wire [15:0] running_hours_threshold,
   // Frequency detector, 0.01 Hz and 0.1 % units
   input wire [15:0] freq_detect_level_one,
   input wire [9:0] freq_detect_hysteresis_one,
   // Drive outputs
   output reg [15:0] outFreq_q,
   output reg outReverse_q,
   output reg running_q,
   output reg [1:0] startMethodActive_q,
   output reg startBlocked_q,
   output reg deadTime_q,
   // Digital output functions
   output reg freq_detector_one_q,
   output reg poweronArrive_q,
   output reg runtimeArrive_q,
   // Hour counters
   output wire [15:0] poweron_hours_counter,
   output wire [15:0] running_hours_counter
);
   // Band handling: a request inside [p-a, p+a] moves to the nearer edge
   function [15:0] skipBand;
      input [15:0] f;
      input [15:0] p;
      input [15:0] a;
      reg [15:0] lo;
      reg [16:0] hi;
      begin
         lo = (p > a) ? p - a : 16'h0000;
         hi = {1'b0, p} + {1'b0, a};
         skipBand = f;
         if (f >= lo && {1'b0, f} <= hi) begin
            if (f <= p) begin
               skipBand = lo;
            end else begin
               skipBand = hi[16] ? 16'hffff : hi[15:0];
            end
         end
      end
   endfunction

   function [15:0] satSub;
      input [15:0] a;
      input [15:0] b;
      begin
         satSub = (a > b) ? a - b : 16'h0000;
      end
   endfunction

   // Pin synchronisers, first stage feeds only the second
   reg [5:0] syncA_q;
   reg [5:0] syncB_q;
   reg faultPrev_q;
   reg powerUp_q;
   reg blocked_q;
   reg lastJog_q;
   reg dirRev_q;
   reg state_q;
   reg [21:0] deadCnt_q;
   reg [8:0] tickCnt_q;
   reg [15:0] msCnt_q;
   reg [1:0] selA;
   reg [15:0] selAcc;
   reg [15:0] selDec;
   reg [15:0] floorFreq;
   reg floorStop;
   wire runS = syncB_q[0];
   wire jogS = syncB_q[1];
   wire revS = syncB_q[2];
   wire [1:0] accSelS = syncB_q[4:3];
   wire faultS = syncB_q[5];
   wire tick = (tickCnt_q == `DAF_TICK_CYC - 1);
   wire msTick = (msCnt_q == `DAF_MS_CYC - 1);
   wire [15:0] rampFreq;

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         syncA_q <= 6'h00;
         syncB_q <= 6'h00;
         tickCnt_q <= 9'h000;
         msCnt_q <= 16'h0000;
      end else begin
         syncA_q <= {faultReset, accelSelect, reverseCmd, jogCmd, runCmd};
         syncB_q <= syncA_q;
         tickCnt_q <= tick ? 9'h000 : tickCnt_q + 9'h001;
         msCnt_q <= msTick ? 16'h0000 : msCnt_q + 16'h0001;
      end
   end

   // Start protection; tick counter times the sync fill after reset
   wire cmdAny = runS | jogS;
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         powerUp_q <= 1'b1;
         blocked_q <= 1'b0;
         faultPrev_q <= 1'b0;
      end else begin
         faultPrev_q <= faultS;
         if (powerUp_q) begin
            if (tickCnt_q == 9'h002) begin
               powerUp_q <= 1'b0;
               blocked_q <= start_protection_select & cmdAny;
            end
         end else if (faultS & ~faultPrev_q & start_protection_select & cmdAny) begin
            blocked_q <= 1'b1;
         end else if (~cmdAny) begin
            blocked_q <= 1'b0;
         end
      end
   end

   wire armed = ~powerUp_q & ~blocked_q & ~(faultS & ~faultPrev_q & start_protection_select);
   wire jogOn = jogS & armed;
   wire active = (runS | jogS) & armed;
   wire revBlock = revS & reverse_inhibit;
   wire dirMismatch = active & ~revBlock & (revS != dirRev_q);
   wire [15:0] baseReq = jogOn ? jog_target_freq : freqSetpoint;

   always @* begin
      selA = jogOn ? 2'h0 : accSelS;
      case (selA)
         2'h0: begin
            selAcc = accel_time_set_one;
            selDec = decel_time_set_one;
         end
         2'h1: begin
            selAcc = accel_time_set_two;
            selDec = decel_time_set_two;
         end
         2'h2: begin
            selAcc = accel_time_set_three;
            selDec = decel_time_set_three;
         end
         default: begin
            selAcc = accel_time_set_four;
            selDec = decel_time_set_four;
         end
      endcase
      if (jogOn | (~active & lastJog_q)) begin
         selAcc = jog_accel_time;
         selDec = jog_decel_time;
      end
   end

   always @* begin
      floorFreq = baseReq;
      floorStop = 1'b0;
      if (baseReq < lowerLimitFreq) begin
         case (below_floor_action)
            `DAF_FLOOR_LIMIT: floorFreq = lowerLimitFreq;
            `DAF_FLOOR_STOP: begin
               floorFreq = 16'h0000;
               floorStop = 1'b1;
            end
            default: floorFreq = 16'h0000;
         endcase
      end
   end

   wire skipOn = (skip_point_one != 16'h0000) | (skip_point_two != 16'h0000);
   wire [15:0] skipFreq = skipOn ?
      skipBand(skipBand(floorFreq, skip_point_one, skip_band_amplitude),
               skip_point_two, skip_band_amplitude) : floorFreq;
   wire holdZero = ~active | revBlock | floorStop | dirMismatch | (state_q == `DAF_ST_DEAD);
   wire [15:0] target = holdZero ? 16'h0000 : skipFreq;
   // Coast only for normal run; a jog always ramps down
   wire coast = ~active & ~lastJog_q & (stop_method_select != 2'h0);

   daf_ramp ramp (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tick(tick),
      .forceZero(coast),
      .target(target),
      .accTime(selAcc),
      .decTime(selDec),
      .maxFreq(maxFreq),
      .freq_q(rampFreq)
   );

   // Direction change: reach 0 Hz, wait the dead time, then flip
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= `DAF_ST_RUN;
         dirRev_q <= 1'b0;
         deadCnt_q <= 22'h000000;
         lastJog_q <= 1'b0;
      end else begin
         if (active) begin
            lastJog_q <= jogOn;
         end
         case (state_q)
            `DAF_ST_RUN: begin
               if (dirMismatch && rampFreq == 16'h0000) begin
                  deadCnt_q <= 22'h000000;
                  if (direction_change_dead_time == 22'h000000) begin
                     dirRev_q <= revS;
                  end else begin
                     state_q <= `DAF_ST_DEAD;
                  end
               end
            end
            `DAF_ST_DEAD: begin
               if (deadCnt_q >= direction_change_dead_time) begin
                  dirRev_q <= revS & ~reverse_inhibit;
                  state_q <= `DAF_ST_RUN;
               end else if (msTick) begin
                  deadCnt_q <= deadCnt_q + 22'h000001;
               end
            end
            default: state_q <= `DAF_ST_RUN;
         endcase
      end
   end

   // Droop: reduction scales with load, full amount at rated load
   wire [29:0] droopProd = droop_amount * loadLevel;
   wire [29:0] droopFull = droopProd / `DAF_DROOP_DIV;
   wire [15:0] droopRed = (droopFull[29:16] != 14'h0000) ? 16'hffff : droopFull[15:0];
   wire [25:0] hystProd = freq_detect_level_one * freq_detect_hysteresis_one;
   wire [25:0] hystFull = hystProd / `DAF_HYST_DIV;
   wire [15:0] releaseLvl = satSub(freq_detect_level_one, hystFull[15:0]);
   wire runningNow = (active & ~floorStop) | (rampFreq != 16'h0000);

   daf_hours #(
      .CYC_PER_SEC(CYC_PER_SEC),
      .SEC_PER_HOUR(`DAF_SEC_PER_HOUR)
   ) poweronHours (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .enable(1'b1),
      .hours_q(poweron_hours_counter)
   );

   daf_hours #(
      .CYC_PER_SEC(CYC_PER_SEC),
      .SEC_PER_HOUR(`DAF_SEC_PER_HOUR)
   ) runningHours (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .enable(running_q),
      .hours_q(running_hours_counter)
   );

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         outFreq_q <= 16'h0000;
         outReverse_q <= 1'b0;
         running_q <= 1'b0;
         startMethodActive_q <= 2'h0;
         startBlocked_q <= 1'b0;
         deadTime_q <= 1'b0;
         freq_detector_one_q <= 1'b0;
         poweronArrive_q <= 1'b0;
         runtimeArrive_q <= 1'b0;
      end else begin
         outFreq_q <= satSub(rampFreq, droopRed);
         outReverse_q <= dirRev_q;
         running_q <= runningNow;
         startMethodActive_q <= jogOn ? 2'h0 : start_method_select;
         startBlocked_q <= blocked_q | (powerUp_q & start_protection_select);
         deadTime_q <= (state_q == `DAF_ST_DEAD);
         if (outFreq_q > freq_detect_level_one) begin
            freq_detector_one_q <= 1'b1;
         end else if (outFreq_q < releaseLvl) begin
            freq_detector_one_q <= 1'b0;
         end
         poweronArrive_q <= poweron_hours_counter >= poweron_hours_threshold;
         runtimeArrive_q <= running_hours_counter >= running_hours_threshold;
      end
   end
endmodule // daf_aux

// ===== verilog/daf_hours.v
// Saturating whole-hour counter
`timescale 1ns/1ps
`include "daf_regs.vh"
module daf_hours #(
   parameter CYC_PER_SEC = `DAF_CLK_HZ,
   parameter SEC_PER_HOUR = `DAF_SEC_PER_HOUR
) (
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // Count while high
   input wire enable,
   // Elapsed hours
   output reg [15:0] hours_q
);
   reg [25:0] cyc_q;
   reg [11:0] sec_q;
   wire secDone = (cyc_q == CYC_PER_SEC[25:0] - 26'h0000001);
   wire hourDone = (sec_q == SEC_PER_HOUR[11:0] - 12'h001);

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cyc_q <= 26'h0000000;
         sec_q <= 12'h000;
         hours_q <= `DAF_HOURS_RST;
      end else if (enable) begin
         cyc_q <= secDone ? 26'h0000000 : cyc_q + 26'h0000001;
         if (secDone) begin
            sec_q <= hourDone ? 12'h000 : sec_q + 12'h001;
            if (hourDone && hours_q != `DAF_HOURS_MAX) begin
               hours_q <= hours_q + 16'h0001;
            end
         end
      end
   end
endmodule // daf_hours

// ===== verilog/daf_ramp.v
// Linear frequency ramp generator
`timescale 1ns/1ps
`include "daf_regs.vh"
module daf_ramp (
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // Control
   input wire tick,
   input wire forceZero,
   input wire [15:0] target,
   input wire [15:0] accTime,
   input wire [15:0] decTime,
   input wire [15:0] maxFreq,
   // Result
   output reg [15:0] freq_q
);
   reg [31:0] acc_q;
   wire up = target > freq_q;
   wire [15:0] rampTime = up ? accTime : decTime;
   wire [31:0] thr = rampTime * `DAF_TICKS_PER_TENTH;
   wire [31:0] accNew = acc_q + {16'h0000, maxFreq};
   wire [31:0] accRem = accNew - thr;

   // One step per tick at most for a nonzero time: ramps shorter than max/100000 s are stretched; a zero time jumps to target
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         freq_q <= 16'h0000;
         acc_q <= 32'h00000000;
      end else if (forceZero) begin
         freq_q <= 16'h0000;
         acc_q <= 32'h00000000;
      end else if (freq_q == target) begin
         acc_q <= 32'h00000000;
      end else if (tick) begin
         if (rampTime == 16'h0000) begin
            freq_q <= target;
         end else if (accNew >= thr) begin
            freq_q <= up ? freq_q + 16'h0001 : freq_q - 16'h0001;
            acc_q <= (accRem >= thr) ? 32'h00000000 : accRem;
         end else begin
            acc_q <= accNew;
         end
      end
   end
endmodule // daf_ramp
